// ==== verilog/rsle_top.sv ====
// relay status led encoder: channel, supply and system leds
// assumes relay and supply inputs come from logic on hclk,
// AHB-Lite single word transfers, one slave on the bus,
// relay inputs are levels, high while a channel is active,
// blink counts are parameters, defaults sized for 100 MHz
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
//
// Contract
// - two dual colour channel leds, red, green and both together.
// - pair a shows channels one and two, pair b three and four.
// - channels one and two both off gives a dark pair a led.
// - channel one only lights pair a red.
// - channel two only lights pair a green.
// - both channels on lights pair a red and green, yellow.
// - pair b maps channels three and four the same way.
// - supply led steady green while all channel power is enabled.
// - bus communication gives two short blinks in a chosen colour.
module rsle_top #(
  parameter int ON_CYC  = rsle_pkg::BLINK_ON_CYC,
  parameter int GAP_CYC = rsle_pkg::BLINK_GAP_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        relay_channel_one,
  input  wire logic        relay_channel_two,
  input  wire logic        relay_channel_three,
  input  wire logic        relay_channel_four,
  input  wire logic        supply_enable,
  output logic [1:0]       pair_a_indicator,
  output logic [1:0]       pair_b_indicator,
  output logic             supply_indicator,
  output logic [2:0]       system_indicator,
  output logic             irq
);

  // ************************************************************
  // bus address phase capture
  // ************************************************************
  logic        wr_q;
  logic [11:0] adr_q;
  // taken only while the bus is ready and the slot is NONSEQ or SEQ
  wire         ap_valid = hsel && hready && htrans[1];

  // write request flag for the following data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_q <= 1'b0;
    else
      wr_q <= ap_valid && hwrite;
  end

  // address of the last accepted address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      adr_q <= 12'h000;
    else if (ap_valid)
      adr_q <= haddr[11:0];
  end

  // zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ************************************************************
  // register decode
  // ************************************************************
  wire we_ctrl = wr_q && (adr_q == rsle_pkg::ADDR_CTRL);
  wire we_ist  = wr_q && (adr_q == rsle_pkg::ADDR_IRQ_ST);
  wire we_msk  = wr_q && (adr_q == rsle_pkg::ADDR_IRQ_MSK);
  wire we_blk  = wr_q && (adr_q == rsle_pkg::ADDR_BLINK);

  // register storage
  logic [rsle_pkg::CTRL_W-1:0] ctrl_q;
  logic [rsle_pkg::IRQ_W-1:0]  ist_q;
  logic [rsle_pkg::IRQ_W-1:0]  msk_q;

  // control register, every field written at once
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_q <= rsle_pkg::CTRL_RST;
    else if (we_ctrl)
      ctrl_q <= hwdata[rsle_pkg::CTRL_W-1:0];
  end

  // interrupt mask register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      msk_q <= rsle_pkg::IRQ_RST;
    else if (we_msk)
      msk_q <= hwdata[rsle_pkg::IRQ_W-1:0];
  end

  // ************************************************************
  // blink sequencer
  // ************************************************************
  rsle_blink_if bl ();
  // previous levels for the edge detectors
  logic comm_q;
  logic cfg_q;
  logic [3:0] rel_q;
  // software start: a one written to the blink register
  wire  blink_wr = we_blk && hwdata[0];
  wire  comm_rise = ctrl_q[rsle_pkg::CTRL_COMM] && !comm_q;
  assign bl.start = comm_rise || blink_wr;

  rsle_blink #(
    .ON_CYC  (ON_CYC),
    .GAP_CYC (GAP_CYC)
  ) u_blink (
    .hclk    (hclk),
    .hresetn (hresetn),
    .bl      (bl)
  );

  // ************************************************************
  // interrupt events, set wins over clear
  // ************************************************************
  // relay levels, channel one in bit 0
  wire [3:0] rel_now = {relay_channel_four, relay_channel_three,
                        relay_channel_two, relay_channel_one};
  wire       cfg_now = ctrl_q[rsle_pkg::CTRL_CFGERR];
  // event sources, one per status bit
  logic [rsle_pkg::IRQ_W-1:0] ev;
  assign ev[rsle_pkg::IRQ_RELAY]  = (rel_now != rel_q);
  assign ev[rsle_pkg::IRQ_COMM]   = comm_rise;
  assign ev[rsle_pkg::IRQ_CFGERR] = cfg_now && !cfg_q;
  wire [rsle_pkg::IRQ_W-1:0] clr = we_ist ? hwdata[rsle_pkg::IRQ_W-1:0] : '0;
  // set wins: an event in the clearing cycle stays pending
  wire [rsle_pkg::IRQ_W-1:0] ist_d = (ist_q & ~clr) | ev;

  // previous levels for the edge detectors
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rel_q  <= 4'h0;
      comm_q <= 1'b0;
      cfg_q  <= 1'b0;
    end
    else
    begin
      rel_q  <= rel_now;
      comm_q <= ctrl_q[rsle_pkg::CTRL_COMM];
      cfg_q  <= cfg_now;
    end
  end

  // sticky status bits, cleared by writing ones
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ist_q <= rsle_pkg::IRQ_RST;
    else
      ist_q <= ist_d;
  end

  // level interrupt from the next status under the mask
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |(ist_d & msk_q);
  end

  // ************************************************************
  // led colour encoding
  // ************************************************************
  // one led per pair
  // lower channel of a pair lights red, upper lights green, both show yellow
  wire [1:0] pair_d [2];
  for (genvar p = 0; p < 2; p++)
  begin : g_pair
    assign pair_d[p] = {rel_now[2*p+1], rel_now[2*p]};
  end

  // blink colour field of control
  rsle_pkg::rsle_col_t col_sel;
  assign col_sel = rsle_pkg::rsle_col_t'(ctrl_q[rsle_pkg::CTRL_COL_LO +: 2]);

  // blink colour lookup
  function automatic logic [2:0] col_code(input rsle_pkg::rsle_col_t c);
    unique case (c)
      rsle_pkg::RSLE_C_RED:    col_code = rsle_pkg::COL_RED;
      rsle_pkg::RSLE_C_GREEN:  col_code = rsle_pkg::COL_GREEN;
      rsle_pkg::RSLE_C_BLUE:   col_code = rsle_pkg::COL_BLUE;
      rsle_pkg::RSLE_C_YELLOW: col_code = rsle_pkg::COL_YELLOW;
    endcase
  endfunction

  // steady system colour, error or update first
  wire       yel_cond = ctrl_q[rsle_pkg::CTRL_CFGERR] || ctrl_q[rsle_pkg::CTRL_FWUPD];
  wire [2:0] steady   = yel_cond ? rsle_pkg::COL_YELLOW :
                        ctrl_q[rsle_pkg::CTRL_TERM] ? rsle_pkg::COL_BLUE :
                        rsle_pkg::COL_GREEN;
  wire [2:0] sys_d = !bl.busy ? steady :
                     bl.lit ? col_code(col_sel) : rsle_pkg::COL_OFF;

  // ************************************************************
  // led output registers
  // ************************************************************
  // registered pair leds
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pair_a_indicator <= 2'h0;
      pair_b_indicator <= 2'h0;
    end
    else
    begin
      pair_a_indicator <= pair_d[0];
      pair_b_indicator <= pair_d[1];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      supply_indicator <= 1'b0;
    else
      supply_indicator <= supply_enable;
  end

  // registered system led
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      system_indicator <= rsle_pkg::COL_OFF;
    else
      system_indicator <= sys_d;
  end

  // ************************************************************
  // read data
  // ************************************************************
  // status word: blink busy, supply enable, two spare bits, relays four..one
  wire [7:0]  status_w = {bl.busy, supply_enable, 2'h0, rel_now};
  wire [11:0] ap_a     = haddr[11:0];
  // read taken at an accepted address phase
  wire        rd_take  = ap_valid && !hwrite;

  // read word for one byte address; unmapped and write-only offsets read zero
  function automatic logic [31:0] rd_word(
    input logic [11:0]                 a,
    input logic [rsle_pkg::CTRL_W-1:0] c,
    input logic [7:0]                  s,
    input logic [rsle_pkg::IRQ_W-1:0]  i,
    input logic [rsle_pkg::IRQ_W-1:0]  m
  );
    rd_word = 32'h0000_0000;
    case (a)
      rsle_pkg::ADDR_CTRL:    rd_word = 32'(c);
      rsle_pkg::ADDR_STATUS:  rd_word = 32'(s);
      rsle_pkg::ADDR_IRQ_ST:  rd_word = 32'(i);
      rsle_pkg::ADDR_IRQ_MSK: rd_word = 32'(m);
      default:                rd_word = 32'h0000_0000;
    endcase
  endfunction

  // address-phase lookup so the word stands through the data phase
  wire [31:0] rd_mux_ap = rd_word(ap_a, ctrl_q, status_w, ist_q, msk_q);

  // read data registered at the address phase edge, held until the next read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_take)
      hrdata <= rd_mux_ap;
  end

  // whole-word bus: transfer size and upper address bits are not decoded
  wire unused_ok = (|hsize) ^ (|haddr[31:12]);
endmodule

// ==== verilog/rsle_pkg.sv ====
// package for the relay status led encoder
// assumes one 100 MHz clock and a 32-bit AHB-Lite register bus
package rsle_pkg;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_IRQ_ST  = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MSK = 12'h00C;
  localparam logic [11:0] ADDR_BLINK   = 12'h010;

  // ************************************************************
  // control field positions and reset values
  // ************************************************************
  localparam int CTRL_TERM   = 0;
  localparam int CTRL_CFGERR = 1;
  localparam int CTRL_FWUPD  = 2;
  localparam int CTRL_COMM   = 3;
  localparam int CTRL_COL_LO = 4;
  localparam int CTRL_W      = 6;
  localparam logic [5:0] CTRL_RST = 6'h00;

  // ************************************************************
  // interrupt status bits: relay change, comm start, cfg error
  // ************************************************************
  localparam int IRQ_RELAY  = 0;
  localparam int IRQ_COMM   = 1;
  localparam int IRQ_CFGERR = 2;
  localparam int IRQ_W      = 3;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // ************************************************************
  // blink timing: short blink on and gap, in ms
  // ************************************************************
  localparam int CLK_MHZ      = 100;
  localparam int BLINK_ON_MS  = 50;
  localparam int BLINK_GAP_MS = 100;
  localparam int BLINK_ON_CYC  = BLINK_ON_MS * CLK_MHZ * 1000;
  localparam int BLINK_GAP_CYC = BLINK_GAP_MS * CLK_MHZ * 1000;

  // ************************************************************
  // led colour codes, bit0 red, bit1 green, bit2 blue
  // ************************************************************
  localparam logic [2:0] COL_OFF    = 3'h0;
  localparam logic [2:0] COL_RED    = 3'h1;
  localparam logic [2:0] COL_GREEN  = 3'h2;
  localparam logic [2:0] COL_YELLOW = 3'h3;
  localparam logic [2:0] COL_BLUE   = 3'h4;

  typedef enum logic [1:0] {RSLE_C_RED, RSLE_C_GREEN, RSLE_C_BLUE, RSLE_C_YELLOW} rsle_col_t;

endpackage

// ==== verilog/rsle_blink_if.sv ====
// interface between the encoder top and the blink sequencer
// assumes both ends on hclk
`timescale 1ns/10ps
interface rsle_blink_if;
  logic start;
  logic busy;
  logic lit;
  modport ctl (output start, input busy, input lit);
  modport seq (input start, output busy, output lit);
endinterface

// ==== verilog/rsle_blink.sv ====
// two short blink sequencer
// assumes start is a one-cycle pulse on hclk
`timescale 1ns/10ps
module rsle_blink #(
  parameter int ON_CYC  = rsle_pkg::BLINK_ON_CYC,
  parameter int GAP_CYC = rsle_pkg::BLINK_GAP_CYC
) (
  input  wire logic   hclk,
  input  wire logic   hresetn,
  rsle_blink_if.seq   bl
);
  typedef enum logic [2:0] {RSLE_IDLE, RSLE_ON1, RSLE_GAP, RSLE_ON2, RSLE_TAIL} rsle_bst_t;
  rsle_bst_t   st_q;
  logic [31:0] cnt_q;
  wire         cnt_done = (cnt_q == 32'h0000_0000);

  // ************************************************************
  // sequence: on, gap, on, gap, then idle
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q  <= RSLE_IDLE;
      cnt_q <= 32'h0000_0000;
    end
    else if (st_q == RSLE_IDLE)
    begin
      if (bl.start)
      begin
        st_q  <= RSLE_ON1;
        cnt_q <= 32'(ON_CYC - 1);
      end
    end
    else if (!cnt_done)
      cnt_q <= cnt_q - 32'h0000_0001;
    else
    begin
      unique case (st_q)
        RSLE_ON1:
        begin
          st_q  <= RSLE_GAP;
          cnt_q <= 32'(GAP_CYC - 1);
        end
        RSLE_GAP:
        begin
          st_q  <= RSLE_ON2;
          cnt_q <= 32'(ON_CYC - 1);
        end
        RSLE_ON2:
        begin
          st_q  <= RSLE_TAIL;
          cnt_q <= 32'(GAP_CYC - 1);
        end
        RSLE_TAIL:
          st_q <= RSLE_IDLE;
        default:
          st_q <= RSLE_IDLE;
      endcase
    end
  end

  // status back to the top
  assign bl.busy = (st_q != RSLE_IDLE);
  assign bl.lit  = (st_q == RSLE_ON1) || (st_q == RSLE_ON2);
endmodule

// ==== sim/rsle_top_asserts.sv ====
// checker for the led encoder top: led mapping and bus answers
// assumes it is bound to rsle_top and sees only its ports
`timescale 1ns/10ps
module rsle_top_asserts #(
  parameter int ON_CYC  = 4,
  parameter int GAP_CYC = 6
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        relay_channel_one,
  input wire logic        relay_channel_two,
  input wire logic        relay_channel_three,
  input wire logic        relay_channel_four,
  input wire logic        supply_enable,
  input wire logic [1:0]  pair_a_indicator,
  input wire logic [1:0]  pair_b_indicator,
  input wire logic        supply_indicator,
  input wire logic [2:0]  system_indicator,
  input wire logic        irq
);
  // ************************************************************
  // led and bus checks, all on hclk
  // ************************************************************
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_pair_a_map: assert property ($past(hresetn) |-> pair_a_indicator ==
    {$past(relay_channel_two), $past(relay_channel_one)}) else $error("pair a led wrong");
  chk_pair_b_map: assert property ($past(hresetn) |-> pair_b_indicator ==
    {$past(relay_channel_four), $past(relay_channel_three)}) else $error("pair b led wrong");
  chk_pair_a_dark: assert property (!relay_channel_one && !relay_channel_two
    |=> pair_a_indicator == 2'h0) else $error("pair a not dark");
  chk_pair_b_yellow: assert property (relay_channel_three && relay_channel_four
    |=> pair_b_indicator == 2'h3) else $error("pair b not yellow");
  chk_supply_led: assert property ($past(hresetn) |->
    supply_indicator == $past(supply_enable)) else $error("supply led wrong");
  chk_sys_colour: assert property (system_indicator <= rsle_pkg::COL_BLUE)
    else $error("system led colour illegal");
  chk_ready_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
  chk_unmapped_zero: assert property (hsel && hready && htrans[1] && !hwrite &&
    haddr > 32'h0000_0010 |=> hrdata == 32'h0000_0000) else $error("unmapped read not zero");

  // count dark system led cycles; a blink gap is the longest dark run
  logic [31:0] dark_run;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dark_run <= 32'h0000_0000;
    else if (system_indicator == rsle_pkg::COL_OFF)
      dark_run <= dark_run + 32'h0000_0001;
    else
      dark_run <= 32'h0000_0000;
  end
  chk_dark_bounded: assert property (dark_run <= 32'(GAP_CYC))
    else $error("system led dark too long");

  cov_pair_yellow: cover property (pair_a_indicator == 2'h3);
  cov_blink_dark: cover property (system_indicator == rsle_pkg::COL_OFF);
  cov_irq_rise: cover property ($rose(irq));
endmodule

bind rsle_top rsle_top_asserts #(.ON_CYC(ON_CYC), .GAP_CYC(GAP_CYC)) u_chk (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .relay_channel_one,
  .relay_channel_two, .relay_channel_three, .relay_channel_four, .supply_enable,
  .pair_a_indicator, .pair_b_indicator, .supply_indicator, .system_indicator, .irq);

// ==== sim/relay_status_led_encoder_test.sv ====
// testbench for the led encoder top
// assumes 0 wait state AHB-Lite slave, short blink counts
`timescale 1ns/10ps
module relay_status_led_encoder_test;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  rly;
  logic        supply_enable;
  logic [1:0]  pair_a;
  logic [1:0]  pair_b;
  logic        supply_led;
  logic [2:0]  sys_led;
  logic        irq;
  logic [31:0] rd;
  int          errors;
  int          comparisons;
  int          cycles;
  logic [2:0]  col_tab [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
  logic [31:0] cv [5] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0002, 32'h0000_0004,
                          32'h0000_0003};
  logic [2:0]  ce [5] = '{3'h2, 3'h4, 3'h3, 3'h3, 3'h3};

  rsle_top #(.ON_CYC(4), .GAP_CYC(6)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .relay_channel_one(rly[0]), .relay_channel_two(rly[1]), .relay_channel_three(rly[2]),
    .relay_channel_four(rly[3]), .supply_enable(supply_enable), .pair_a_indicator(pair_a),
    .pair_b_indicator(pair_b), .supply_indicator(supply_led), .system_indicator(sys_led),
    .irq(irq));

  // ************************************************************
  // clock, timeout and shared tasks
  // ************************************************************
  initial
  begin
    hclk = 0;
    forever #5 hclk = ~hclk;
  end

  // cut a hang short
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles > 4000)
    begin
      errors++;
      end_sim();
    end
  end

  task end_sim;
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask

  // one single word transfer, address phase then data phase
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task rchk(input string n, input logic [11:0] a, input logic [31:0] e);
    xfer(0, a, 32'h0000_0000);
    chk(n, e, rd);
  endtask

  // wait until the system led is dark, or lit
  task wdark(input bit d);
    int k;
    k = 0;
    while (((sys_led === 3'h0) != d) && k < 60)
    begin
      @(posedge hclk);
      k++;
    end
    if (k == 60)
      chk("blink wait", 0, 1);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, rly, supply_enable} = '0;
    {errors, comparisons, cycles} = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    repeat (2) @(posedge hclk);
    chk("system reset", 32'(rsle_pkg::COL_GREEN), 32'(sys_led));
    rchk("ctrl reset", rsle_pkg::ADDR_CTRL, 32'h0000_0000);
    rchk("mask reset", rsle_pkg::ADDR_IRQ_MSK, 32'h0000_0000);
    for (int i = 0; i < 16; i++)
    begin
      rly <= i[3:0];
      repeat (2) @(posedge hclk);
      chk("pair a", 32'(i[1:0]), 32'(pair_a));
      chk("pair b", 32'(i[3:2]), 32'(pair_b));
    end
    supply_enable <= 1;
    repeat (2) @(posedge hclk);
    chk("supply on", 32'h0000_0001, 32'(supply_led));
    rchk("status", rsle_pkg::ADDR_STATUS, 32'h0000_004F);
    supply_enable <= 0;
    repeat (2) @(posedge hclk);
    chk("supply off", 32'h0000_0000, 32'(supply_led));
    for (int i = 0; i < 5; i++)
    begin
      xfer(1, rsle_pkg::ADDR_CTRL, cv[i]);
      repeat (2) @(posedge hclk);
      chk("system", 32'(ce[i]), 32'(sys_led));
    end
    rchk("ctrl", rsle_pkg::ADDR_CTRL, 32'h0000_0003);
    for (int c = 0; c < 4; c++)
    begin
      xfer(1, rsle_pkg::ADDR_CTRL, 32'(c << 4) | (c == 3 ? 32'h0000_0008 : 32'h0000_0000));
      if (c != 3)
        xfer(1, rsle_pkg::ADDR_BLINK, 32'h0000_0001);
      wdark(1);
      wdark(0);
      chk("blink colour", 32'(col_tab[c]), 32'(sys_led));
      wdark(1);
      wdark(0);
      chk("after blink", 32'(rsle_pkg::COL_GREEN), 32'(sys_led));
    end
    rchk("irq status", rsle_pkg::ADDR_IRQ_ST, 32'h0000_0007);
    chk("irq masked", 32'h0000_0000, 32'(irq));
    xfer(1, rsle_pkg::ADDR_IRQ_MSK, 32'h0000_0001);
    repeat (2) @(posedge hclk);
    chk("irq raised", 32'h0000_0001, 32'(irq));
    xfer(1, rsle_pkg::ADDR_IRQ_ST, 32'h0000_0007);
    repeat (3) @(posedge hclk);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    rchk("irq status clr", rsle_pkg::ADDR_IRQ_ST, 32'h0000_0000);
    rly <= 4'h0;
    repeat (3) @(posedge hclk);
    chk("irq relay", 32'h0000_0001, 32'(irq));
    xfer(1, rsle_pkg::ADDR_IRQ_MSK, 32'h0000_0000);
    repeat (2) @(posedge hclk);
    chk("irq mask off", 32'h0000_0000, 32'(irq));
    xfer(1, 12'h100, 32'hFFFF_FFFF);
    rchk("unmapped", 12'h100, 32'h0000_0000);
    rchk("ctrl kept", rsle_pkg::ADDR_CTRL, 32'h0000_0038);
    end_sim();
  end
endmodule
